// ---- inc/osu_pkg.sv ----
// shared types and constants for the operand types and stack unit
package osu_pkg;

   // operand sizes
   typedef enum logic [1:0] {
      OSU_SZ_BYTE = 2'h0,
      OSU_SZ_WORD = 2'h1,
      OSU_SZ_DWORD = 2'h2
   } osu_size_t;

   // operations offered on the command port
   typedef enum logic [3:0] {
      OSU_OP_PUSH = 4'h0,
      OSU_OP_POP = 4'h1,
      OSU_OP_JSR = 4'h2,
      OSU_OP_ENTER = 4'h3,
      OSU_OP_BOOL = 4'h4,
      OSU_OP_EXT = 4'h5,
      OSU_OP_INS = 4'h6,
      OSU_OP_BCD = 4'h7,
      OSU_OP_SETSP = 4'h8,
      OSU_OP_SEXT = 4'h9
   } osu_op_t;

   // one command from the sequencer
   typedef struct packed {
      osu_op_t op;
      osu_size_t size;
      logic [31:0] data;
      logic [31:0] target;
      logic [7:0] reg_mask;
      logic [63:0] field_base;
      logic [4:0] field_off;
      logic [5:0] field_len;
   } osu_cmd_t;

   // one memory request, data right-justified, byte 0 at addr
   typedef struct packed {
      logic we;
      logic [31:0] addr;
      osu_size_t size;
      logic [3:0][7:0] wbytes;
   } osu_mem_req_t;

   // reset values and widths
   localparam logic [31:0] OSU_SP_RESET = 32'h0000_0000;
   localparam logic [31:0] OSU_PC_RESET = 32'h0000_0000;
   localparam int OSU_NUM_REGS = 8;
   localparam int OSU_BCD_DIGITS = 8;
   localparam logic [5:0] OSU_FIELD_MAX = 6'h20;
   localparam logic [3:0] OSU_BCD_RADIX = 4'ha;

   // item length in bytes for a size code
   function automatic logic [31:0] osu_len(input osu_size_t s);
      unique case (s)
         OSU_SZ_BYTE: osu_len = 32'h1;
         OSU_SZ_WORD: osu_len = 32'h2;
         default: osu_len = 32'h4;
      endcase
   endfunction : osu_len

endpackage : osu_pkg

// ---- src/osu_field_unit.sv ----
// bit-field extract and insert over a two-word window
`timescale 1ns/100ps
`default_nettype none
module osu_field_unit import osu_pkg::*; (
   // field window and placement
   input wire logic [63:0] base,
   input wire logic [4:0] off,
   input wire logic [5:0] len,
   // value to insert
   input wire logic [31:0] ins_val,
   // results
   output logic [31:0] ext_val,
   output logic [63:0] ins_word,
   output logic len_ok
);
   logic [63:0] mask; // ones over the field, low aligned
   logic [63:0] shifted; // window moved down to the field start

   // field mask and both results, any bit alignment
   always_comb begin
      len_ok = (len != 6'h0) && (len <= OSU_FIELD_MAX);
      mask = (64'h1 << len) - 64'h1;
      shifted = base >> off;
      ext_val = shifted[31:0] & mask[31:0];
      ins_word = (base & ~(mask << off)) | (({32'h0, ins_val} & mask) << off);
   end
endmodule : osu_field_unit
`default_nettype wire

// ---- src/osu_bcd_unit.sv ----
// packed bcd check and conversion to binary
`timescale 1ns/100ps
`default_nettype none
module osu_bcd_unit import osu_pkg::*; (
   // packed operand and its size
   input wire logic [31:0] bcd,
   input wire osu_size_t size,
   // results
   output logic valid,
   output logic [31:0] bin
);
   logic [3:0] ndig; // digits held by this size
   logic [OSU_BCD_DIGITS-1:0] dig_ok; // one flag per nibble

   genvar g;
   generate
      for (g = 0; g < OSU_BCD_DIGITS; g++) begin : g_dig
         assign dig_ok[g] = (bcd[g*4 +: 4] < OSU_BCD_RADIX) || (4'(g) >= ndig);
      end
   endgenerate

   // unsigned value, most significant digit first
   always_comb begin
      // 2, 4 or 8 digits by size
      unique case (size)
         OSU_SZ_BYTE: ndig = 4'h2;
         OSU_SZ_WORD: ndig = 4'h4;
         default: ndig = 4'h8;
      endcase
      valid = &dig_ok;
      bin = 32'h0;
      // unsigned, 0 to 99 / 9999 / 99999999
      for (int i = OSU_BCD_DIGITS - 1; i >= 0; i--) begin
         if (4'(i) < ndig) begin
            bin = 32'(bin * 32'd10) + {28'h0, bcd[i*4 +: 4]};
         end
      end
   end
endmodule : osu_bcd_unit
`default_nettype wire

// ---- src/osu_stack_unit.sv ----
// operand formats and dual stack pointer engine with memory port
// Notes on behaviour
// - booleans are integers: one true, zero false
// - bit fields 1..32 bits, any alignment
// - each bcd digit is four bits
// - bcd sizes: 2, 4, 8 digits
// - bcd unsigned up to 99, 9999, 99999999
// - user and interrupt pointers, mode selects
// - push: decrement pointer, then write
// - pop: read at pointer, then increment
// - top-of-stack operands use push and pop
// - subroutine jump pushes pc first
// - entry pushes frame pointer and named registers
// - least significant byte at lowest address
// - 8/16/32-bit integers, two's complement signed
`timescale 1ns/100ps
`default_nettype none
module osu_stack_unit import osu_pkg::*; (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // command port
   input wire logic cmd_valid,
   input wire osu_cmd_t cmd,
   output logic cmd_ready,
   // processor context
   input wire logic mode_intr,
   input wire logic [31:0] pc_in,
   input wire logic [31:0] frame_ptr,
   input wire logic [OSU_NUM_REGS-1:0][31:0] gen_regs,
   // results
   output logic done,
   output logic [31:0] result,
   output logic flag,
   output logic [31:0] pc_out,
   output logic [31:0] first_stack_pointer,
   output logic [31:0] second_stack_pointer,
   // memory port
   output logic mem_req,
   output osu_mem_req_t mem_cmd,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack
);

   // main sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_WRITE = 3'h1,
      ST_READ = 3'h2,
      ST_ENTER = 3'h3,
      ST_DONE = 3'h4
   } osu_state_t;

   osu_state_t state_ff, nxt_state; // sequencer state
   osu_cmd_t cmd_ff, nxt_cmd; // command being served
   logic [31:0] usp_ff, nxt_usp; // user stack pointer
   logic [31:0] isp_ff, nxt_isp; // interrupt stack pointer
   logic [31:0] pc_ff, nxt_pc; // program counter result
   logic [31:0] res_ff, nxt_res; // operation result
   logic flag_ff, nxt_flag; // status flag of last operation
   logic done_ff, nxt_done; // one-cycle completion pulse
   logic ready_ff, nxt_ready; // command acceptance
   logic req_ff, nxt_req; // memory request pending
   osu_mem_req_t mreq_ff, nxt_mreq; // memory request body
   logic [OSU_NUM_REGS-1:0] todo_ff, nxt_todo; // registers still to push
   logic intr_ff, nxt_intr; // mode latched with the command

   logic [31:0] ext_val; // extracted field
   logic [63:0] ins_word; // window with field inserted
   logic len_ok; // field length legal
   logic bcd_ok; // all digits in range
   logic [31:0] bcd_bin; // bcd value in binary

   // bit-field helper
   osu_field_unit u_field (
      .base(cmd_ff.field_base),
      .off(cmd_ff.field_off),
      .len(cmd_ff.field_len),
      .ins_val(cmd_ff.data),
      .ext_val(ext_val),
      .ins_word(ins_word),
      .len_ok(len_ok)
   );

   // bcd helper
   osu_bcd_unit u_bcd (
      .bcd(cmd_ff.data),
      .size(cmd_ff.size),
      .valid(bcd_ok),
      .bin(bcd_bin)
   );

   // lowest-numbered register still waiting to be pushed
   function automatic logic [2:0] first_set(input logic [OSU_NUM_REGS-1:0] m);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = OSU_NUM_REGS - 1; i >= 0; i--) begin
         if (m[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction : first_set

   function automatic logic [3:0][7:0] to_lanes(input logic [31:0] v, input osu_size_t s);
      logic [3:0][7:0] b;
      // byte 0 goes to the lowest address
      for (int i = 0; i < 4; i++) begin
         b[i] = (32'(i) < osu_len(s)) ? v[i*8 +: 8] : 8'h0;
      end
      return b;
   endfunction : to_lanes

   // read data trimmed to the item size, zero extended
   function automatic logic [31:0] trim(input logic [31:0] v, input osu_size_t s);
      unique case (s)
         OSU_SZ_BYTE: trim = {24'h0, v[7:0]};
         OSU_SZ_WORD: trim = {16'h0, v[15:0]};
         default: trim = v;
      endcase
   endfunction : trim

   // next-state logic for the whole sequencer
   always_comb begin
      logic [31:0] sp_cur;
      logic [31:0] sp_dec;
      logic [2:0] ridx;
      sp_cur = 32'h0;
      sp_dec = 32'h0;
      ridx = 3'h0;
      nxt_state = state_ff;
      nxt_cmd = cmd_ff;
      nxt_usp = usp_ff;
      nxt_isp = isp_ff;
      nxt_pc = pc_ff;
      nxt_res = res_ff;
      nxt_flag = flag_ff;
      nxt_done = 1'b0;
      nxt_ready = ready_ff;
      nxt_req = req_ff;
      nxt_mreq = mreq_ff;
      nxt_todo = todo_ff;
      nxt_intr = intr_ff;
      sp_cur = intr_ff ? isp_ff : usp_ff;
      unique case (state_ff)
         // wait for a command
         ST_IDLE: begin
            if (cmd_valid) begin
               nxt_cmd = cmd;
               nxt_intr = mode_intr;
               nxt_ready = 1'b0;
               unique case (cmd.op)
                  OSU_OP_PUSH, OSU_OP_JSR, OSU_OP_ENTER: nxt_state = ST_WRITE;
                  OSU_OP_POP: nxt_state = ST_READ;
                  // datatype work takes one cycle in done
                  default: nxt_state = ST_DONE;
               endcase
               if (cmd.op == OSU_OP_JSR) begin
                  // the return pc is the pushed item
                  nxt_cmd.data = pc_in;
                  nxt_cmd.size = OSU_SZ_DWORD;
               end
               if (cmd.op == OSU_OP_ENTER) begin
                  // frame pointer first, then named registers
                  nxt_cmd.data = frame_ptr;
                  nxt_cmd.size = OSU_SZ_DWORD;
                  nxt_todo = cmd.reg_mask;
               end
            end
         end
         // decrement the pointer, then issue the write
         ST_WRITE: begin
            // pointer moves down before the write
            sp_dec = sp_cur - osu_len(cmd_ff.size);
            if (intr_ff) begin
               nxt_isp = sp_dec;
            end else begin
               nxt_usp = sp_dec;
            end
            nxt_req = 1'b1;
            nxt_mreq.we = 1'b1;
            nxt_mreq.addr = sp_dec;
            nxt_mreq.size = cmd_ff.size;
            nxt_mreq.wbytes = to_lanes(cmd_ff.data, cmd_ff.size);
            nxt_state = ST_ENTER;
         end
         // wait for the write; entry walks its register list
         ST_ENTER: begin
            if (mem_ack) begin
               nxt_req = 1'b0;
               if ((cmd_ff.op == OSU_OP_ENTER) && (todo_ff != '0)) begin
                  ridx = first_set(todo_ff);
                  nxt_todo[ridx] = 1'b0;
                  nxt_cmd.data = gen_regs[ridx];
                  nxt_state = ST_WRITE;
               end else begin
                  nxt_state = ST_DONE;
               end
            end
         end
         // read at the pointer, then increment
         ST_READ: begin
            if (!req_ff) begin
               nxt_req = 1'b1;
               nxt_mreq.we = 1'b0;
               nxt_mreq.addr = sp_cur;
               nxt_mreq.size = cmd_ff.size;
               nxt_mreq.wbytes = '0;
            end else if (mem_ack) begin
               // read first, pointer moves up after
               nxt_req = 1'b0;
               nxt_res = trim(mem_rdata, cmd_ff.size);
               if (intr_ff) begin
                  nxt_isp = isp_ff + osu_len(cmd_ff.size);
               end else begin
                  nxt_usp = usp_ff + osu_len(cmd_ff.size);
               end
               nxt_state = ST_DONE;
            end
         end
         // finish: compute datatype results, pulse done
         ST_DONE: begin
            nxt_done = 1'b1;
            nxt_ready = 1'b1;
            nxt_flag = 1'b1;
            nxt_state = ST_IDLE;
            unique case (cmd_ff.op)
               OSU_OP_BOOL: begin
                  // nonzero integer reads as true = 1
                  nxt_res = (trim(cmd_ff.data, cmd_ff.size) != 32'h0) ? 32'h1 : 32'h0;
               end
               OSU_OP_EXT: begin
                  // field read at any bit offset
                  nxt_res = ext_val;
                  nxt_flag = len_ok;
               end
               OSU_OP_INS: begin
                  // low word of the updated window
                  nxt_res = ins_word[31:0];
                  nxt_flag = len_ok;
               end
               OSU_OP_BCD: begin
                  // unsigned decimal value, flag says digits valid
                  nxt_res = bcd_bin;
                  nxt_flag = bcd_ok;
               end
               OSU_OP_SEXT: begin
                  unique case (cmd_ff.size)
                     OSU_SZ_BYTE: nxt_res = {{24{cmd_ff.data[7]}}, cmd_ff.data[7:0]};
                     OSU_SZ_WORD: nxt_res = {{16{cmd_ff.data[15]}}, cmd_ff.data[15:0]};
                     default: nxt_res = cmd_ff.data;
                  endcase
               end
               OSU_OP_SETSP: begin
                  // explicit load of the active pointer
                  if (intr_ff) begin
                     nxt_isp = cmd_ff.data;
                  end else begin
                     nxt_usp = cmd_ff.data;
                  end
               end
               OSU_OP_JSR: begin
                  // control moves only after the push
                  nxt_pc = cmd_ff.target;
               end
               OSU_OP_PUSH, OSU_OP_ENTER: nxt_res = sp_cur;
               // pop result was captured on the read
               default: nxt_res = res_ff;
            endcase
         end
         // state codes 5..7 are unused; recover to idle
         default: begin
            nxt_state = ST_IDLE;
            nxt_req = 1'b0;
            nxt_ready = 1'b1;
         end
      endcase
   end

   // sequencer registers, synchronous reset
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_ff <= ST_IDLE;
         cmd_ff <= '0;
         usp_ff <= OSU_SP_RESET;
         isp_ff <= OSU_SP_RESET;
         pc_ff <= OSU_PC_RESET;
         res_ff <= 32'h0;
         flag_ff <= 1'b0;
         done_ff <= 1'b0;
         ready_ff <= 1'b1;
         req_ff <= 1'b0;
         mreq_ff <= '0;
         todo_ff <= '0;
         intr_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cmd_ff <= nxt_cmd;
         usp_ff <= nxt_usp;
         isp_ff <= nxt_isp;
         pc_ff <= nxt_pc;
         res_ff <= nxt_res;
         flag_ff <= nxt_flag;
         done_ff <= nxt_done;
         ready_ff <= nxt_ready;
         req_ff <= nxt_req;
         mreq_ff <= nxt_mreq;
         todo_ff <= nxt_todo;
         intr_ff <= nxt_intr;
      end
   end

   // outputs straight from flip-flops
   assign cmd_ready = ready_ff;
   assign done = done_ff;
   assign result = res_ff;
   assign flag = flag_ff;
   assign pc_out = pc_ff;
   assign first_stack_pointer = usp_ff;
   assign second_stack_pointer = isp_ff;
   assign mem_req = req_ff;
   assign mem_cmd = mreq_ff;

endmodule : osu_stack_unit
`default_nettype wire

// ---- tb/osu_stack_checker.sv ----
// port assertions for the operand and stack unit
`timescale 1ns/100ps
`default_nettype none
module osu_stack_checker import osu_pkg::*; (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // command port
   input wire logic cmd_valid,
   input wire osu_cmd_t cmd,
   input wire logic cmd_ready,
   // processor context
   input wire logic mode_intr,
   input wire logic [31:0] pc_in,
   input wire logic [31:0] frame_ptr,
   input wire logic [OSU_NUM_REGS-1:0][31:0] gen_regs,
   // results
   input wire logic done,
   input wire logic [31:0] result,
   input wire logic flag,
   input wire logic [31:0] pc_out,
   input wire logic [31:0] first_stack_pointer,
   input wire logic [31:0] second_stack_pointer,
   // memory port
   input wire logic mem_req,
   input wire osu_mem_req_t mem_cmd,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack
);
   logic take; // command accepted at this edge
   logic [31:0] len; // item length of the offered command
   logic [31:0] msk; // offered data cut to its size
   logic [31:0] sp; // pointer chosen by the latched mode
   logic [31:0] oth; // the pointer that must not move
   osu_op_t op_ff; // latched operation
   logic mode_ff; // latched mode
   logic [31:0] len_ff, dat_ff, pc_ff, tgt_ff, sp_ff, oth_ff, fp_ff; // latched context

   assign take = cmd_valid && cmd_ready;
   assign len = cmd.size == OSU_SZ_BYTE ? 32'h1 : cmd.size == OSU_SZ_WORD ? 32'h2 : 32'h4;
   assign msk = cmd.size == OSU_SZ_BYTE ? {24'h0, cmd.data[7:0]} :
                cmd.size == OSU_SZ_WORD ? {16'h0, cmd.data[15:0]} : cmd.data;
   assign sp = mode_ff ? second_stack_pointer : first_stack_pointer;
   assign oth = mode_ff ? first_stack_pointer : second_stack_pointer;

   // keep the context of each command, since mode is only sampled at the take
   always_ff @(posedge ref_clk) begin
      if (take) begin
         op_ff <= cmd.op;
         mode_ff <= mode_intr;
         len_ff <= len;
         dat_ff <= msk;
         pc_ff <= pc_in;
         fp_ff <= frame_ptr;
         tgt_ff <= cmd.target;
         sp_ff <= mode_intr ? second_stack_pointer : first_stack_pointer;
         oth_ff <= mode_intr ? first_stack_pointer : second_stack_pointer;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);

   take_gap_a: assert property (take |=> !cmd_ready) else $error("ready high after a take");
   fast_done_a: assert property (take && cmd.op >= OSU_OP_BOOL |-> ##1 !done ##1 done)
      else $error("register op not done two cycles on");
   push_addr_a: assert property ($rose(mem_req) && op_ff == OSU_OP_PUSH |->
      mem_cmd.we && mem_cmd.addr == sp_ff - len_ff && sp == mem_cmd.addr) else $error("push not at lowered pointer");
   push_data_a: assert property ($rose(mem_req) && op_ff == OSU_OP_PUSH |-> mem_cmd.wbytes == dat_ff)
      else $error("push bytes misplaced");
   jsr_push_a: assert property ($rose(mem_req) && op_ff == OSU_OP_JSR |-> mem_cmd.we &&
      mem_cmd.wbytes == pc_ff && mem_cmd.addr == sp_ff - 32'h4 && mem_cmd.size == OSU_SZ_DWORD)
      else $error("subroutine jump pushed wrong item");
   enter_fp_a: assert property ($rose(mem_req) && op_ff == OSU_OP_ENTER && mem_cmd.addr == sp_ff - 32'h4 |->
      mem_cmd.we && mem_cmd.wbytes == fp_ff) else $error("entry did not push frame pointer first");
   pop_addr_a: assert property ($rose(mem_req) && op_ff == OSU_OP_POP |->
      !mem_cmd.we && mem_cmd.addr == sp_ff && sp == sp_ff) else $error("pop not read at pointer");
   push_end_a: assert property (done && op_ff == OSU_OP_PUSH |-> sp == sp_ff - len_ff && result == sp)
      else $error("push pointer step wrong");
   pop_end_a: assert property (done && op_ff == OSU_OP_POP |-> sp == sp_ff + len_ff)
      else $error("pop pointer step wrong");
   jsr_end_a: assert property (done && op_ff == OSU_OP_JSR |-> pc_out == tgt_ff)
      else $error("jump target not taken");
   bool_val_a: assert property (done && op_ff == OSU_OP_BOOL |-> result == {31'h0, dat_ff != 32'h0})
      else $error("boolean result not one or zero");
   other_sp_a: assert property (done |-> oth == oth_ff) else $error("inactive pointer moved");
   req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
      else $error("memory request dropped early");
endmodule : osu_stack_checker

bind osu_stack_unit osu_stack_checker i_chk (.ref_clk(ref_clk), .srst(srst), .cmd_valid(cmd_valid),
   .cmd(cmd), .cmd_ready(cmd_ready), .mode_intr(mode_intr), .pc_in(pc_in), .frame_ptr(frame_ptr),
   .gen_regs(gen_regs), .done(done), .result(result), .flag(flag), .pc_out(pc_out),
   .first_stack_pointer(first_stack_pointer), .second_stack_pointer(second_stack_pointer),
   .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
`default_nettype wire

// ---- tb/osu_mem_model.sv ----
// behavioural byte memory on the far side of the stack unit
`timescale 1ns/100ps
`default_nettype none
module osu_mem_model import osu_pkg::*; (
   // clock
   input wire logic ref_clk,
   // request side
   input wire logic mem_req,
   input wire osu_mem_req_t mem_cmd,
   input wire logic [3:0] wait_cyc,
   // answer side
   output logic [31:0] mem_rdata,
   output logic mem_ack
);
   logic [7:0] mem [0:255]; // byte store, address wraps at 256
   logic [3:0] cnt_ff; // cycles waited on the pending request
   logic hold_ff; // request already answered, wait for it to drop
   logic [31:0] rd; // assembled read word
   int n; // bytes in the request

   initial begin
      mem_ack = 1'b0;
      mem_rdata = 32'h5a5a_a5a5;
      cnt_ff = 4'h0;
      hold_ff = 1'b0;
   end

   // answer after wait_cyc cycles, once per request
   always @(posedge ref_clk) begin
      n = mem_cmd.size == OSU_SZ_BYTE ? 1 : mem_cmd.size == OSU_SZ_WORD ? 2 : 4;
      mem_ack <= 1'b0;
      // idle data lines toggle so a stale value is never mistaken for an answer
      mem_rdata <= ~mem_rdata;
      if (!mem_req) begin
         cnt_ff <= 4'h0;
         hold_ff <= 1'b0;
      end else if (!hold_ff && cnt_ff >= wait_cyc) begin
         mem_ack <= 1'b1;
         hold_ff <= 1'b1;
         for (int i = 0; i < 4; i++) begin
            if (mem_cmd.we && i < n) mem[8'(mem_cmd.addr + i)] = mem_cmd.wbytes[i];
            rd[8*i +: 8] = i < n ? mem[8'(mem_cmd.addr + i)] : 8'h0;
         end
         mem_rdata <= rd;
      end else begin
         cnt_ff <= cnt_ff + 4'h1;
      end
   end
endmodule : osu_mem_model
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the operand and stack unit
`timescale 1ns/100ps
`default_nettype none
module testbench import osu_pkg::*;;
   logic ref_clk, srst, cmd_valid, cmd_ready, mode_intr, done, flag, mem_req, mem_ack; // port signals
   logic [31:0] pc_in, frame_ptr, result, pc_out, first_sp, second_sp, mem_rdata; // port words
   logic [OSU_NUM_REGS-1:0][31:0] gen_regs; // register file seen by enter
   osu_cmd_t cmd, nc; // driven command and staged fields
   osu_mem_req_t mem_cmd; // memory request
   logic [3:0] mem_wait; // memory answer delay
   int mismatches, checks, cyc; // counters

   osu_stack_unit i_dut (.ref_clk(ref_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .mode_intr(mode_intr), .pc_in(pc_in), .frame_ptr(frame_ptr),
      .gen_regs(gen_regs), .done(done), .result(result), .flag(flag), .pc_out(pc_out),
      .first_stack_pointer(first_sp), .second_stack_pointer(second_sp), .mem_req(mem_req),
      .mem_cmd(mem_cmd), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   osu_mem_model i_mem (.ref_clk(ref_clk), .mem_req(mem_req), .mem_cmd(mem_cmd),
      .wait_cyc(mem_wait), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

   // 50 mhz clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // hang guard, far above the hundred or so cycles needed
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         conclude();
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task conclude;
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude

   function automatic logic [31:0] rd32(input logic [7:0] a);
      rd32 = {i_mem.mem[a+8'h3], i_mem.mem[a+8'h2], i_mem.mem[a+8'h1], i_mem.mem[a]};
   endfunction : rd32

   // one command at the falling edge, then wait for its done pulse
   task go(input osu_op_t op, input osu_size_t sz, input logic [31:0] d, input logic m);
      int k;
      @(negedge ref_clk);
      cmd = nc;
      cmd.op = op;
      cmd.size = sz;
      cmd.data = d;
      mode_intr = m;
      cmd_valid = 1'b1;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 60) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      check({31'h0, done}, 32'h1);
   endtask : go

   task t_bool;
      for (int s = 0; s < 3; s++) begin
         go(OSU_OP_BOOL, osu_size_t'(s), 32'h0, 1'b0);
         check(result, 32'h0);
         go(OSU_OP_BOOL, osu_size_t'(s), 32'h80, 1'b0);
         check(result, 32'h1);
      end
   endtask : t_bool

   // lengths at both edges of the legal range and just outside
   task t_field;
      logic [5:0] lens [4];
      logic [63:0] w;
      lens = '{6'd1, 6'd32, 6'd33, 6'd0};
      nc.field_base = 64'h0123_4567_89ab_cdef;
      nc.field_off = 5'd31;
      foreach (lens[i]) begin
         nc.field_len = lens[i];
         go(OSU_OP_EXT, OSU_SZ_DWORD, 32'h0, 1'b0);
         check({31'h0, flag}, {31'h0, lens[i] >= 6'd1 && lens[i] <= 6'd32});
         // value judged only for legal lengths, never on the unit's own flag
         if (lens[i] != 6'd0 && lens[i] <= 6'd32)
            check(result, 32'((nc.field_base >> 31) & ((64'h1 << lens[i]) - 64'h1)));
      end
      nc.field_off = 5'd30;
      nc.field_len = 6'd8;
      w = (nc.field_base & ~(64'hff << 30)) | (64'ha5 << 30);
      go(OSU_OP_INS, OSU_SZ_DWORD, 32'ha5, 1'b0);
      check(result, w[31:0]);
   endtask : t_field

   task bcd_one(input osu_size_t sz, input logic [31:0] d, input logic [31:0] e, input logic f);
      go(OSU_OP_BCD, sz, d, 1'b0);
      check({31'h0, flag}, {31'h0, f});
      if (f) check(result, e);
   endtask : bcd_one

   task t_bcd;
      bcd_one(OSU_SZ_BYTE, 32'h99, 32'h63, 1'b1);
      bcd_one(OSU_SZ_WORD, 32'h9999, 32'h270f, 1'b1);
      bcd_one(OSU_SZ_DWORD, 32'h9999_9999, 32'h05f5_e0ff, 1'b1);
      bcd_one(OSU_SZ_BYTE, 32'h1a, 32'h0, 1'b0);
      bcd_one(OSU_SZ_WORD, 32'h0a00, 32'h0, 1'b0);
   endtask : t_bcd

   // two stacks, mixed sizes, slow memory on the pops
   task t_stack;
      go(OSU_OP_SETSP, OSU_SZ_DWORD, 32'h80, 1'b0);
      go(OSU_OP_SETSP, OSU_SZ_DWORD, 32'hc0, 1'b1);
      check(first_sp, 32'h80);
      check(second_sp, 32'hc0);
      go(OSU_OP_PUSH, OSU_SZ_BYTE, 32'hab, 1'b0);
      check(first_sp, 32'h7f);
      check({24'h0, i_mem.mem[8'h7f]}, 32'hab);
      go(OSU_OP_PUSH, OSU_SZ_WORD, 32'h1234, 1'b1);
      check(second_sp, 32'hbe);
      check({16'h0, i_mem.mem[8'hbf], i_mem.mem[8'hbe]}, 32'h1234);
      mem_wait = 4'h3;
      go(OSU_OP_POP, OSU_SZ_WORD, 32'h0, 1'b1);
      check(result, 32'h1234);
      check(second_sp, 32'hc0);
      go(OSU_OP_POP, OSU_SZ_BYTE, 32'h0, 1'b0);
      check(result, 32'hab);
      check(first_sp, 32'h80);
      mem_wait = 4'h0;
   endtask : t_stack

   task t_calls;
      nc.target = 32'h0000_4400;
      go(OSU_OP_JSR, OSU_SZ_DWORD, 32'h0, 1'b0);
      check(pc_out, 32'h0000_4400);
      check(first_sp, 32'h7c);
      check(rd32(8'h7c), pc_in);
      nc.reg_mask = 8'h05;
      go(OSU_OP_ENTER, OSU_SZ_DWORD, 32'h0, 1'b1);
      check(second_sp, 32'hb4);
      check(rd32(8'hbc), frame_ptr);
      // frame pointer low byte sits right above the top byte of register 0
      check({16'h0, i_mem.mem[8'hbc], i_mem.mem[8'hbb]}, 32'h6810);
      check(rd32(8'hb8), gen_regs[0]);
      check(rd32(8'hb4), gen_regs[2]);
   endtask : t_calls

   task t_sext;
      go(OSU_OP_SEXT, OSU_SZ_BYTE, 32'h80, 1'b0);
      check(result, 32'hffff_ff80);
      go(OSU_OP_SEXT, OSU_SZ_WORD, 32'h7fff, 1'b0);
      check(result, 32'h0000_7fff);
   endtask : t_sext

   // main sequence
   initial begin
      srst = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
      nc = '0;
      mode_intr = 1'b0;
      pc_in = 32'h0000_1236;
      frame_ptr = 32'h0000_2468;
      for (int i = 0; i < OSU_NUM_REGS; i++) gen_regs[i] = 32'h1000_0000 + 32'(i);
      mem_wait = 4'h0;
      mismatches = 0;
      checks = 0;
      cyc = 0;
      repeat (16) @(negedge ref_clk);
      srst = 1'b0;
      check(first_sp, 32'h0);
      check({31'h0, cmd_ready}, 32'h1);
      t_bool();
      t_field();
      t_bcd();
      t_stack();
      t_calls();
      t_sext();
      conclude();
   end
endmodule : testbench
`default_nettype wire
